// >>> inc/bcs_pkg.sv
// Purpose: constants for breaker control and supervision
// Assumes: 32-bit AHB-Lite register bus, line-cycle tick input
// Notes on behaviour
// RULE1 - closed shown when aux a on, or aux b off, per configured inputs
// RULE2 - open shown when aux a off, or aux b on, per configured inputs
// RULE3 - both state indications stay low if no aux input is configured
// RULE4 - any input may take either aux role; defaults input 1 and 2
// RULE5 - close relay, default relay 5, pulses for 45 line cycles
// RULE6 - close from panel, test, remote command, or remote close input
// RULE7 - close blocked by lockout, trip relay, trouble, closed, open request
// RULE8 - panel request warns if already there or state or slow alarm
// RULE9 - open relay, default trip relay, held 30 cycles after request ends
// RULE10 - open from panel, test, remote command, or remote open input
// RULE11 - trip coil alarm: no trickle while closed and trip relay off
// RULE12 - close coil alarm: no trickle while open and second relay off
// RULE13 - failure mode off, internal, external or both; off disables all
// RULE14 - internal: after overcurrent trip and delay, current high trips
// RULE15 - failure delay 0 to 9999 line cycles, one cycle steps
// RULE16 - phase and ground limits 0.1 to 5 of rating, or disabled; code stores any 10-bit limit value without clamping
// RULE17 - failure trip drives its relay, default relay 3
// RULE18 - lockout blocks close until its own reset command; code also clears it when failure mode is off
// RULE19 - external: initiate trips at once; delayed current check locks
// RULE20 - disagreement alarm when both aux inputs match over 30 cycles
// RULE21 - trouble input, default input 4, blocks close while true
// RULE22 - slow alarm if close not reached within 40 cycles
// RULE23 - slow alarm if open not reached within 15 cycles
// RULE24 - timers step on line tick and clear when condition drops
`default_nettype none
package bcs_pkg;
   localparam logic [7:0] BCS_OFF_INSEL = 8'h00;
   localparam logic [7:0] BCS_OFF_CTRL = 8'h04;
   localparam logic [7:0] BCS_OFF_OUTSEL = 8'h08;
   localparam logic [7:0] BCS_OFF_BFDLY = 8'h0C;
   localparam logic [7:0] BCS_OFF_BFLIM = 8'h10;
   localparam logic [7:0] BCS_OFF_CMD = 8'h14;
   localparam logic [7:0] BCS_OFF_STAT = 8'h18;
   localparam logic [31:0] BCS_INSEL_RST = 32'h0000BA98;
   localparam logic [31:0] BCS_CTRL_RST = 32'h00000000;
   localparam logic [31:0] BCS_OUTSEL_RST = 32'h00007204;
   localparam logic [13:0] BCS_BFDLY_RST = 14'h0000;
   localparam logic [9:0] BCS_LIM_RST = 10'h000;
   localparam int BCS_ROLES = 6;
   localparam int BCS_CTRL_PB = 0;
   localparam int BCS_CTRL_RM = 1;
   localparam int BCS_CTRL_BFM = 2;
   localparam int BCS_CTRL_TMON = 4;
   localparam int BCS_CTRL_CMON = 5;
   localparam int BCS_CTRL_OASN = 6;
   localparam int BCS_CTRL_CASN = 7;
   localparam int BCS_CTRL_SLOW = 8;
   localparam int BCS_LIM_GND = 16;
   localparam int BCS_PRI_TRIP = 0;
   localparam int BCS_SEC_TRIP = 1;
   localparam logic [5:0] BCS_CLOSE_CYC = 6'd45;
   localparam logic [5:0] BCS_OPEN_CYC = 6'd30;
   localparam logic [5:0] BCS_DISAG_CYC = 6'd30;
   localparam logic [5:0] BCS_SLOWC_CYC = 6'd40;
   localparam logic [5:0] BCS_SLOWO_CYC = 6'd15;
   localparam logic [13:0] BCS_BFDLY_MAX = 14'd9999;
   localparam logic [9:0] BCS_LIM_MIN = 10'd10;
   localparam logic [9:0] BCS_LIM_MAX = 10'd500;
   typedef enum logic [1:0] {
      BCS_BF_OFF, BCS_BF_INT, BCS_BF_EXT, BCS_BF_BOTH
   } bcs_bfm_e;
endpackage
`default_nettype wire

// >>> verilog/bcs_top.sv
// Purpose: breaker state, close/open commands, coil and failure supervision
// Assumes: hready from this single slave, line_tick one hclk wide
// Notes: all state frozen while ce is low, bus included
//
// The address map and register access over AHB-Lite are this design's own decisions.
`default_nettype none
module bcs_top
   import bcs_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic line_tick,
   input wire logic [7:0] contact_inputs,
   input wire logic oc_trip,
   input wire logic [9:0] phase_level,
   input wire logic [9:0] ground_level,
   input wire logic trip_trickle_ok,
   input wire logic close_trickle_ok,
   output logic [7:0] relay_out,
   output logic brk_closed,
   output logic brk_open,
   output logic bf_trip,
   output logic bf_lockout,
   output logic disagree_alarm,
   output logic slow_alarm,
   output logic trip_coil_alarm,
   output logic close_coil_alarm,
   output logic panel_warning
);
   typedef struct packed {
      logic rdy;
      logic resp;
      logic [31:0] rdata;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] insel;
      logic [31:0] ctrl;
      logic [31:0] outsel;
      logic [13:0] bfdly;
      logic [9:0] plim;
      logic [9:0] glim;
      logic rc_q;
      logic closed;
      logic opened;
      logic cl_act;
      logic [5:0] cl_cnt;
      logic op_act;
      logic [5:0] op_cnt;
      logic bi_run;
      logic [13:0] bi_cnt;
      logic [13:0] be_cnt;
      logic bf_trip;
      logic bf_lock;
      logic [5:0] dg_cnt;
      logic dg_alm;
      logic sc_run;
      logic [5:0] sc_cnt;
      logic so_run;
      logic [5:0] so_cnt;
      logic slow_alm;
      logic tc_alm;
      logic cc_alm;
      logic warn;
      logic [7:0] relay;
   } bcs_st_s;

   bcs_st_s st_r;
   bcs_st_s st_nxt;
   logic [BCS_ROLES-1:0] role_en;
   logic [BCS_ROLES-1:0] role_val;
   logic [7:0] cmd;
   logic [31:0] rmux;
   logic addr_rd;
   logic addr_wr;
   logic known;
   logic cl_now;
   logic m_int;
   logic m_ext;
   logic over;
   logic fire;
   logic cl_req;
   logic op_req;
   logic inhibit;
   logic slow_on;
   logic bfm_off;

   // role i: select at [4i+2:4i], enable at 4i+3; a, b, init, trouble,
   // remote close, remote open
   genvar gi;
   generate
      for (gi = 0; gi < BCS_ROLES; gi++) begin : g_role
         assign role_en[gi] = st_r.insel[4*gi+3];
         assign role_val[gi] = role_en[gi] &
            contact_inputs[st_r.insel[4*gi +: 3]]; // RULE4
      end
   endgenerate

   // read data taken at address phase: zero wait state, registered hrdata
   always_comb begin
      rmux = 32'h00000000;
      case (haddr[7:0])
         BCS_OFF_INSEL: rmux = st_r.insel;
         BCS_OFF_CTRL: rmux = st_r.ctrl;
         BCS_OFF_OUTSEL: rmux = st_r.outsel;
         BCS_OFF_BFDLY: rmux = {18'h00000, st_r.bfdly};
         BCS_OFF_BFLIM: rmux = {6'h00, st_r.glim, 6'h00, st_r.plim};
         BCS_OFF_STAT: rmux = {14'h0000, st_r.relay, role_val[3],
            st_r.warn, st_r.cc_alm, st_r.tc_alm, st_r.slow_alm,
            st_r.dg_alm, st_r.bf_lock, st_r.bf_trip, st_r.opened,
            st_r.closed};
         default: rmux = 32'h00000000;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      addr_rd = hsel & htrans[1] & hready & ~hwrite;
      addr_wr = hsel & htrans[1] & hready & hwrite;
      cmd = 8'h00;
      st_nxt.rdy = 1'b1;
      st_nxt.resp = 1'b0;
      st_nxt.wr_pend = addr_wr;
      if (addr_wr) begin
         st_nxt.wr_addr = haddr[7:0];
      end
      if (addr_rd) begin
         st_nxt.rdata = rmux;
      end
      if (st_r.wr_pend) begin
         case (st_r.wr_addr)
            BCS_OFF_INSEL: st_nxt.insel = hwdata;
            BCS_OFF_CTRL: st_nxt.ctrl = hwdata;
            BCS_OFF_OUTSEL: st_nxt.outsel = hwdata;
            BCS_OFF_BFDLY: begin
               // out-of-range delay clamps to the top of the range
               st_nxt.bfdly = (hwdata[13:0] > BCS_BFDLY_MAX) ?
                  BCS_BFDLY_MAX : hwdata[13:0]; // RULE15
            end
            BCS_OFF_BFLIM: begin
               st_nxt.plim = hwdata[9:0]; // RULE16
               st_nxt.glim = hwdata[BCS_LIM_GND +: 10]; // RULE16
            end
            BCS_OFF_CMD: cmd = hwdata[7:0];
            default: cmd = 8'h00;
         endcase
      end

      // breaker state from configured aux contacts
      known = role_en[0] | role_en[1]; // RULE3
      cl_now = role_en[0] ? role_val[0] : ~role_val[1];
      st_nxt.closed = known & cl_now; // RULE1
      st_nxt.opened = known & ~cl_now; // RULE2

      // breaker failure
      bfm_off = st_r.ctrl[BCS_CTRL_BFM +: 2] == BCS_BF_OFF;
      m_int = st_r.ctrl[BCS_CTRL_BFM +: 2] == BCS_BF_INT ||
         st_r.ctrl[BCS_CTRL_BFM +: 2] == BCS_BF_BOTH; // RULE13
      m_ext = st_r.ctrl[BCS_CTRL_BFM +: 2] == BCS_BF_EXT ||
         st_r.ctrl[BCS_CTRL_BFM +: 2] == BCS_BF_BOTH; // RULE13
      // zero limit means disabled
      over = (st_r.plim != BCS_LIM_RST && phase_level > st_r.plim) ||
         (st_r.glim != BCS_LIM_RST && ground_level > st_r.glim); // RULE16
      fire = 1'b0;
      if (!m_int) begin
         st_nxt.bi_run = 1'b0;
         st_nxt.bi_cnt = 14'h0000;
      end else if (oc_trip) begin
         st_nxt.bi_run = 1'b1; // RULE14
         st_nxt.bi_cnt = 14'h0000;
      end else if (st_r.bi_run) begin
         if (!over) begin
            st_nxt.bi_run = 1'b0; // RULE24
         end else if (st_r.bi_cnt >= st_r.bfdly) begin
            fire = 1'b1; // RULE14
            st_nxt.bi_run = 1'b0;
         end else if (line_tick) begin
            st_nxt.bi_cnt = st_r.bi_cnt + 14'h0001; // RULE24
         end
      end
      // the two modes share only the delay, the current check and the result: they run independently
      if (!(m_ext & role_val[2])) begin
         st_nxt.be_cnt = 14'h0000; // RULE24
      end else if (st_r.be_cnt >= st_r.bfdly) begin
         fire = fire | over; // RULE19
      end else if (line_tick) begin
         st_nxt.be_cnt = st_r.be_cnt + 14'h0001;
      end
      if (bfm_off) begin
         st_nxt.bf_trip = 1'b0; // RULE13
         st_nxt.bf_lock = 1'b0;
      end else if (fire) begin
         st_nxt.bf_trip = 1'b1;
         st_nxt.bf_lock = 1'b1;
      end else if (cmd[6]) begin
         // the dedicated reset or failure mode off clears it; set wins over clear
         st_nxt.bf_trip = 1'b0; // RULE18
         st_nxt.bf_lock = 1'b0; // RULE18
      end

      // command requests
      st_nxt.rc_q = role_val[4];
      cl_req = (cmd[0] & st_r.ctrl[BCS_CTRL_PB]) | cmd[2] |
         (cmd[4] & st_r.ctrl[BCS_CTRL_RM]) |
         (role_val[4] & ~st_r.rc_q); // RULE6
      op_req = (cmd[1] & st_r.ctrl[BCS_CTRL_PB]) | cmd[3] |
         (cmd[5] & st_r.ctrl[BCS_CTRL_RM]) | role_val[5] |
         (m_ext & role_val[2]); // RULE10 RULE19
      inhibit = st_nxt.bf_lock | st_r.relay[BCS_PRI_TRIP] |
         role_val[3] | st_r.closed | op_req; // RULE7 RULE18 RULE21

      // close pulse: a running pulse is cut the moment an inhibit appears
      if (inhibit) begin
         st_nxt.cl_act = 1'b0; // RULE7
         st_nxt.cl_cnt = 6'h00;
      end else if (cl_req && !st_r.cl_act) begin
         st_nxt.cl_act = 1'b1; // RULE5
         st_nxt.cl_cnt = BCS_CLOSE_CYC;
      end else if (st_r.cl_act && line_tick) begin
         st_nxt.cl_cnt = st_r.cl_cnt - 6'h01; // RULE5
         st_nxt.cl_act = st_r.cl_cnt != 6'h01;
      end

      // open: held while requested, then for the hold time
      if (op_req) begin
         st_nxt.op_act = 1'b1; // RULE9
         st_nxt.op_cnt = BCS_OPEN_CYC;
      end else if (st_r.op_act && line_tick) begin
         st_nxt.op_cnt = st_r.op_cnt - 6'h01; // RULE9
         st_nxt.op_act = st_r.op_cnt != 6'h01;
      end

      // contact disagreement
      if (role_en[0] && role_en[1] && role_val[0] == role_val[1]) begin
         if (line_tick && st_r.dg_cnt <= BCS_DISAG_CYC) begin
            st_nxt.dg_cnt = st_r.dg_cnt + 6'h01; // RULE20
         end
      end else begin
         st_nxt.dg_cnt = 6'h00; // RULE24
      end
      st_nxt.dg_alm = st_nxt.dg_cnt > BCS_DISAG_CYC; // RULE20

      // slow breaker timing
      slow_on = st_r.ctrl[BCS_CTRL_SLOW] & known;
      if (!slow_on || st_r.closed) begin
         st_nxt.sc_run = 1'b0; // RULE24
      end else if (!st_r.cl_act && st_nxt.cl_act) begin
         st_nxt.sc_run = 1'b1;
         st_nxt.sc_cnt = 6'h00;
      end else if (st_r.sc_run && line_tick) begin
         st_nxt.sc_cnt = st_r.sc_cnt + 6'h01;
         if (st_r.sc_cnt == BCS_SLOWC_CYC) begin
            st_nxt.sc_run = 1'b0; // RULE22
         end
      end
      if (!slow_on || st_r.opened) begin
         st_nxt.so_run = 1'b0; // RULE24
      end else if (!st_r.op_act && st_nxt.op_act) begin
         st_nxt.so_run = 1'b1;
         st_nxt.so_cnt = 6'h00;
      end else if (st_r.so_run && line_tick) begin
         st_nxt.so_cnt = st_r.so_cnt + 6'h01;
         if (st_r.so_cnt == BCS_SLOWO_CYC) begin
            st_nxt.so_run = 1'b0; // RULE23
         end
      end
      if ((st_r.sc_run && line_tick && st_r.sc_cnt == BCS_SLOWC_CYC &&
           !st_r.closed && slow_on) ||
          (st_r.so_run && line_tick && st_r.so_cnt == BCS_SLOWO_CYC &&
           !st_r.opened && slow_on)) begin
         st_nxt.slow_alm = 1'b1; // RULE22 RULE23
      end else if (cmd[7]) begin
         st_nxt.slow_alm = 1'b0;
      end

      // coil supervision
      st_nxt.tc_alm = known & st_r.ctrl[BCS_CTRL_TMON] &
         st_r.ctrl[BCS_CTRL_OASN] & st_r.closed &
         ~st_r.relay[BCS_PRI_TRIP] & ~trip_trickle_ok; // RULE11
      st_nxt.cc_alm = known & st_r.ctrl[BCS_CTRL_CMON] &
         st_r.ctrl[BCS_CTRL_CASN] & st_r.opened &
         ~st_r.relay[BCS_SEC_TRIP] & ~close_trickle_ok; // RULE12

      // panel warning is sticky until cleared; set wins
      if (st_r.ctrl[BCS_CTRL_PB] &&
          ((cmd[0] && (st_r.closed || st_r.dg_alm || st_r.slow_alm)) ||
           (cmd[1] && (st_r.opened || st_r.dg_alm || st_r.slow_alm))))
      begin
         st_nxt.warn = 1'b1; // RULE8
      end else if (cmd[7]) begin
         st_nxt.warn = 1'b0;
      end

      // relay map; several functions may share one relay
      st_nxt.relay = 8'h00;
      st_nxt.relay[st_r.outsel[2:0]] = st_nxt.cl_act; // RULE5
      if (st_nxt.op_act) begin
         st_nxt.relay[st_r.outsel[6:4]] = 1'b1; // RULE9
      end
      if (st_nxt.bf_trip) begin
         st_nxt.relay[st_r.outsel[10:8]] = 1'b1; // RULE17
      end
      if (st_nxt.dg_alm | st_nxt.slow_alm | st_nxt.tc_alm |
          st_nxt.cc_alm) begin
         st_nxt.relay[st_r.outsel[14:12]] = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
         st_r.rdy <= 1'b1;
         st_r.insel <= BCS_INSEL_RST; // RULE4
         st_r.ctrl <= BCS_CTRL_RST; // RULE13
         st_r.outsel <= BCS_OUTSEL_RST;
         st_r.bfdly <= BCS_BFDLY_RST;
         st_r.plim <= BCS_LIM_RST;
         st_r.glim <= BCS_LIM_RST;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout = st_r.rdy;
   assign hresp = st_r.resp;
   assign hrdata = st_r.rdata;
   assign relay_out = st_r.relay;
   assign brk_closed = st_r.closed;
   assign brk_open = st_r.opened;
   assign bf_trip = st_r.bf_trip;
   assign bf_lockout = st_r.bf_lock;
   assign disagree_alarm = st_r.dg_alm;
   assign slow_alarm = st_r.slow_alm;
   assign trip_coil_alarm = st_r.tc_alm;
   assign close_coil_alarm = st_r.cc_alm;
   assign panel_warning = st_r.warn;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_close_lockout: assert property ( // RULE18
      st_r.cl_act |-> !st_r.bf_lock)
      else $error("close active during lockout");
   a_close_pulse_len: assert property ( // RULE5
      ce && !st_r.cl_act && st_nxt.cl_act |=>
      st_r.cl_act && st_r.cl_cnt == 6'd45)
      else $error("close pulse not loaded with 45");
   a_open_hold: assert property ( // RULE9
      ce && op_req |=> st_r.op_act && st_r.op_cnt == 6'd30)
      else $error("open hold not loaded with 30");
   a_open_drop: assert property ( // RULE9
      ce && st_r.op_act && st_r.op_cnt == 6'd1 && line_tick && !op_req
      |=> !st_r.op_act)
      else $error("open hold did not end");
   a_state_none: assert property ( // RULE3
      ce && !(role_en[0] | role_en[1]) |=> !brk_closed && !brk_open)
      else $error("state shown without aux input");
   a_state_excl: assert property ( // RULE1
      !(brk_closed && brk_open))
      else $error("closed and open both shown");
   a_bf_off: assert property ( // RULE13
      ce && bfm_off |=> !bf_trip && !bf_lockout)
      else $error("failure active with mode off");
   a_trouble_block: assert property ( // RULE21
      ce && role_val[3] |=> !st_r.cl_act)
      else $error("close during breaker trouble");
   a_disagree_set: assert property ( // RULE20
      ce && st_r.dg_cnt == 6'd31 && role_en[0] && role_en[1] &&
      role_val[0] == role_val[1] |=> disagree_alarm)
      else $error("disagreement alarm missing");
   a_slow_close: assert property ( // RULE22
      ce && st_r.sc_run && slow_on && !st_r.closed && line_tick &&
      st_r.sc_cnt == 6'd40 |=> slow_alarm)
      else $error("slow close alarm missing");
   a_bf_relay: assert property ( // RULE17
      ce && st_nxt.bf_trip |=> relay_out[$past(st_r.outsel[10:8])])
      else $error("failure relay not driven");

   c_close_pulse: cover property (ce && !st_r.cl_act && st_nxt.cl_act);
   c_bf_lock: cover property ($rose(bf_lockout));
   c_slow: cover property ($rose(slow_alarm));
   c_disagree: cover property ($rose(disagree_alarm));
endmodule
`default_nettype wire

// >>> verif/bcs_breaker_model.sv
// Purpose: behavioural breaker whose aux contacts follow the coil relays
// Assumes: close coil on relay 5, trip coil on relay 1, dly in line ticks
// Notes: contacts are always driven, so no floating aux level exists
`default_nettype none
module bcs_breaker_model (
   input wire logic hclk,
   input wire logic line_tick,
   input wire logic close_coil,
   input wire logic trip_coil,
   input wire logic [7:0] dly,
   input wire logic stick,
   input wire logic [1:0] coil_bad,
   output logic aux_a,
   output logic aux_b,
   output logic trip_ok,
   output logic close_ok
);
   timeunit 1ns;
   timeprecision 1ps;
   logic closed = 1'b0;
   logic [7:0] cc = 8'h00;
   logic [7:0] tc = 8'h00;
   // mechanism moves only after the coil stayed energised dly ticks
   always @(posedge hclk) begin
      cc <= close_coil ? cc + {7'h00, line_tick} : 8'h00;
      tc <= trip_coil ? tc + {7'h00, line_tick} : 8'h00;
      if (trip_coil && tc >= dly)
         closed <= 1'b0;
      else if (close_coil && cc >= dly)
         closed <= 1'b1;
   end
   assign aux_a = closed;
   // welded aux b copies aux a, giving a contact disagreement
   assign aux_b = stick ? closed : !closed;
   assign trip_ok = !coil_bad[0];
   assign close_ok = !coil_bad[1];
endmodule
`default_nettype wire

// >>> verif/bcs_top_bench.sv
// Purpose: self-checking bench for breaker control and supervision
// Assumes: line tick every TK clocks, breaker aux on inputs 1 and 2
// Notes: ce kept high, since a low ce would drop bus transfers
`default_nettype none
module bcs_top_bench;
   import bcs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 4;
   logic hclk, hresetn, hsel, hwrite, line_tick, oc_trip, stick;
   logic aux_a, aux_b, trip_ok, close_ok, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, coil_bad;
   logic [7:2] ci;
   logic [9:0] phase_level, ground_level;
   logic [7:0] relay_out, dly;
   logic [8:0] mon;
   logic brk_closed, brk_open, bf_trip, bf_lockout, disagree_alarm;
   logic slow_alarm, trip_coil_alarm, close_coil_alarm, panel_warning;
   int errors, num_checks, cyc, tcnt, n, m;
   assign mon = {slow_alarm, relay_out};
   bcs_top bcs_top_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .line_tick(line_tick), .contact_inputs({ci, aux_b, aux_a}),
      .oc_trip(oc_trip), .phase_level(phase_level),
      .ground_level(ground_level), .trip_trickle_ok(trip_ok),
      .close_trickle_ok(close_ok), .relay_out(relay_out),
      .brk_closed(brk_closed), .brk_open(brk_open), .bf_trip(bf_trip),
      .bf_lockout(bf_lockout), .disagree_alarm(disagree_alarm),
      .slow_alarm(slow_alarm), .trip_coil_alarm(trip_coil_alarm),
      .close_coil_alarm(close_coil_alarm), .panel_warning(panel_warning));
   bcs_breaker_model bcs_breaker_model_i (.hclk(hclk),
      .line_tick(line_tick), .close_coil(relay_out[4]),
      .trip_coil(relay_out[0]), .dly(dly), .stick(stick),
      .coil_bad(coil_bad), .aux_a(aux_a), .aux_b(aux_b),
      .trip_ok(trip_ok), .close_ok(close_ok));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // tick rate is ours, far faster than a real line, to keep runs short
   always @(posedge hclk) begin
      tcnt <= (tcnt == TK - 1) ? 0 : tcnt + 1;
      line_tick <= (tcnt == TK - 1);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h00000000, x);
      chk(nm, e, x);
   endtask
   // counts line ticks while a watched bit keeps its level
   task automatic span(input int b, input logic lv, output int k);
      k = 0;
      while (mon[b] === lv) begin
         if (line_tick === 1'b1) k++;
         @(posedge hclk);
      end
   endtask
   task automatic ticks(input int k);
      repeat (k) begin
         @(posedge hclk);
         while (line_tick !== 1'b1) @(posedge hclk);
      end
      @(posedge hclk);
   endtask
   initial begin
      {hresetn, hsel, hwrite, oc_trip, stick} = 5'h00;
      {haddr, hwdata, htrans, coil_bad, ci} = 74'h0;
      {phase_level, ground_level} = 20'h00000;
      {errors, num_checks} = {2{32'sd0}};
      dly = 8'h3C;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc("insel", BCS_OFF_INSEL, 32'h0000BA98);
      rdc("ctrl", BCS_OFF_CTRL, 32'h00000000);
      rdc("outsel", BCS_OFF_OUTSEL, 32'h00007204);
      rdc("unmapped", 8'h1C, 32'h00000000);
      rdc("status", BCS_OFF_STAT, 32'h00000002);
      chk("ready resp", 32'h00000002, {30'h0, hreadyout, hresp});
      chk("open", 32'h1, brk_open);
      wr(BCS_OFF_INSEL, 32'h00DCBA00);
      ticks(1);
      chk("no aux closed", 32'h0, brk_closed);
      chk("no aux open", 32'h0, brk_open);
      wr(BCS_OFF_INSEL, 32'h00FEDC98);
      wr(BCS_OFF_CTRL, 32'h000001F3);
      wr(BCS_OFF_BFDLY, 32'h0000FFFF);
      rdc("delay clamp", BCS_OFF_BFDLY, 32'h0000270F);
      wr(BCS_OFF_CMD, 32'h00000001);
      span(4, 1'b0, n);
      span(8, 1'b0, n);
      chk("slow close ticks", 32'd41, n);
      span(4, 1'b1, m);
      chk("close pulse ticks", 32'd45, n + m);
      chk("no warning", 32'h0, panel_warning);
      dly <= 8'h03;
      wr(BCS_OFF_CMD, 32'h00000001);
      span(4, 1'b0, n);
      span(4, 1'b1, n);
      chk("close cut short", 32'h1, n < 6);
      chk("closed", 32'h1, brk_closed);
      chk("warn slow", 32'h1, panel_warning);
      wr(BCS_OFF_CMD, 32'h00000080);
      wr(BCS_OFF_CMD, 32'h00000001);
      ticks(2);
      chk("warn closed", 32'h1, panel_warning);
      chk("close held", 32'h0, relay_out[4]);
      wr(BCS_OFF_CMD, 32'h00000080);
      coil_bad <= 2'b01;
      ticks(1);
      chk("trip coil", 32'h1, trip_coil_alarm);
      coil_bad <= 2'b10;
      ticks(1);
      chk("trip coil ok", 32'h0, trip_coil_alarm);
      chk("close coil closed", 32'h0, close_coil_alarm);
      dly <= 8'h14;
      ci[7] <= 1'b1;
      span(0, 1'b0, n);
      span(8, 1'b0, n);
      chk("slow open ticks", 32'd16, n);
      ticks(1);
      ci[7] <= 1'b0;
      @(posedge hclk);
      span(0, 1'b1, n);
      chk("open hold ticks", 32'd30, n);
      chk("opened", 32'h1, brk_open);
      chk("close coil", 32'h1, close_coil_alarm);
      coil_bad <= 2'b00;
      dly <= 8'h03;
      wr(BCS_OFF_CMD, 32'h00000080);
      ci[7] <= 1'b1;
      wr(BCS_OFF_CMD, 32'h00000001);
      ticks(1);
      chk("close vs open", 32'h0, relay_out[4]);
      ci[7] <= 1'b0;
      ci[5] <= 1'b1;
      span(0, 1'b1, n);
      wr(BCS_OFF_CMD, 32'h00000010);
      ticks(2);
      chk("trouble", 32'h0, relay_out[4]);
      ci[5] <= 1'b0;
      ticks(1);
      ci[6] <= 1'b1;
      span(4, 1'b0, n);
      span(4, 1'b1, n);
      ci[6] <= 1'b0;
      chk("input close", 32'h1, brk_closed);
      for (int i = 0; i < 3; i++) begin
         wr(BCS_OFF_CMD, 32'h2 << (2 * i));
         span(0, 1'b0, n);
         span(0, 1'b1, n);
         chk("cmd open", 32'h1, brk_open);
         wr(BCS_OFF_CMD, 32'h1 << (2 * i));
         span(4, 1'b0, n);
         span(4, 1'b1, n);
         chk("cmd close", 32'h1, brk_closed);
      end
      stick <= 1'b1;
      ticks(29);
      chk("agree early", 32'h0, disagree_alarm);
      ticks(4);
      chk("disagree", 32'h1, disagree_alarm);
      chk("alarm relay", 32'h1, relay_out[7]);
      stick <= 1'b0;
      wr(BCS_OFF_BFDLY, 32'h0000000A);
      wr(BCS_OFF_BFLIM, 32'h00640064);
      wr(BCS_OFF_CTRL, 32'h000001FB);
      phase_level <= 10'd200;
      ci[4] <= 1'b1;
      // relay must follow within two clocks, well inside one line tick
      repeat (2) @(posedge hclk);
      chk("ext trip now", 32'h1, relay_out[0]);
      ticks(8);
      chk("bf early", 32'h0, bf_trip);
      ticks(4);
      chk("bf trip", 32'h1, bf_trip);
      chk("bf relay", 32'h1, relay_out[2]);
      ci[4] <= 1'b0;
      phase_level <= 10'd0;
      span(0, 1'b1, n);
      wr(BCS_OFF_CMD, 32'h00000001);
      ticks(1);
      chk("lockout", 32'h1, bf_lockout);
      chk("locked close", 32'h0, relay_out[4]);
      wr(BCS_OFF_CMD, 32'h00000040);
      ticks(1);
      chk("bf reset", 32'h0, bf_lockout);
      wr(BCS_OFF_CTRL, 32'h000001F7);
      for (int i = 0; i < 4; i++) begin
         ground_level <= (i == 1) ? 10'd100 : 10'd101;
         if (i >= 2)
            wr(BCS_OFF_CTRL, (i == 2) ? 32'h000001F3 : 32'h000001FF);
         oc_trip <= 1'b1;
         @(posedge hclk);
         oc_trip <= 1'b0;
         ticks(8);
         chk("int early", 32'h0, bf_trip);
         ticks(4);
         chk("int trip", (i % 3 == 0), bf_trip);
         wr(BCS_OFF_CMD, 32'h00000040);
      end
      conclude();
   end
endmodule
`default_nettype wire
